/* File: rtl/mpmc_pkg.sv */
package mpmc_pkg;
   localparam int NPORT = 20;
   localparam int DAC_W = 12;
   localparam int CFG_W = 16;
   // configuration word layout
   localparam int MODE_POS = 12;
   localparam int MODE_W = 4;
   localparam int FLAG_POS = 11;
   localparam int RANGE_POS = 8;
   localparam int RANGE_W = 3;
   localparam int AVG_POS = 5;
   localparam int AVG_W = 3;
   localparam int ASSOC_POS = 0;
   localparam int ASSOC_W = 5;
   localparam logic [3:0] MODE_GPO = 4'h3;
   localparam logic [3:0] MODE_COPY = 4'h4;
   localparam logic [3:0] MODE_DAC = 4'h5;
   localparam logic [3:0] MODE_DACMON = 4'h6;
   localparam logic [3:0] MODE_SE = 4'h7;
   localparam logic [3:0] MODE_DIFF = 4'h8;
   localparam logic [2:0] RANGE_OUT_A = 3'h1;
   localparam logic [2:0] RANGE_OUT_B = 3'h2;
   localparam logic [2:0] RANGE_OUT_C = 3'h3;
   localparam logic [2:0] RANGE_LOW_A = 3'h4;
   localparam logic [2:0] RANGE_LOW_B = 3'h6;
   // address map: paddr[11:7] selects a region, paddr[6:2] the word
   localparam logic [4:0] REGION_CFG = 5'h00;
   localparam logic [4:0] REGION_MISC = 5'h01;
   localparam logic [4:0] REGION_DAC = 5'h02;
   localparam logic [4:0] REGION_RES = 5'h04;
   localparam logic [4:0] IDX_OUT = 5'h00;
   localparam logic [4:0] IDX_IN = 5'h01;
   localparam logic [4:0] IDX_STAT = 5'h02;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [11:0] DAC_RST = 12'h000;
   localparam logic [11:0] CLIP_LO_DEF = 12'h000;
   localparam logic [11:0] CLIP_HI_DEF = 12'h7ff;
   // timing
   localparam int CLK_NS = 100;
   localparam int SETTLE_NS = 1000000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      ST_SCAN = 2'b01,
      ST_WAIT = 2'b10
   } mpmc_state_t;
endpackage : mpmc_pkg

/* File: rtl/mpmc_result_mem.sv */
module mpmc_result_mem #(
   parameter int DEPTH = 20,
   parameter int WIDTH = 12,
   parameter int AW = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data_ff
);
   logic [WIDTH-1:0] mem_ff [0:DEPTH-1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
      end else if (wr_en && (wr_addr < AW'(DEPTH))) begin
         mem_ff[wr_addr] <= wr_data;
      end
   end

   // out-of-range reads give zero rather than an undefined word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data_ff <= '0;
      end else begin
         rd_data_ff <= (rd_addr < AW'(DEPTH)) ? mem_ff[rd_addr] : '0;
      end
   end
endmodule : mpmc_result_mem

/* File: rtl/mpmc_top.sv */
module mpmc_top #(
   parameter int NP = mpmc_pkg::NPORT,
   parameter int SETTLE_CYC = mpmc_pkg::SETTLE_CYC,
   parameter logic [11:0] CLIP_LO = mpmc_pkg::CLIP_LO_DEF,
   parameter logic [11:0] CLIP_HI = mpmc_pkg::CLIP_HI_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NP-1:0] port_in,
   output logic [NP-1:0] pin_out,
   output logic [NP-1:0] pin_oe,
   output logic [NP-1:0] dac_en,
   output logic [NP*12-1:0] dac_level,
   output logic adc_start,
   output logic [4:0] adc_pos,
   output logic [4:0] adc_neg,
   output logic adc_diff,
   output logic [2:0] adc_range,
   output logic adc_ref,
   output logic [2:0] adc_avg,
   input wire logic adc_done,
   input wire logic [11:0] adc_result
);
   // ==========================================================
   // apb slave
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [15:0] cfg_ff [0:NP-1];
   logic [11:0] dac_ff [0:NP-1];
   logic [NP-1:0] out_bits_ff;
   logic [15:0] settle_ff;
   logic [11:0] mem_rdata;
   mpmc_pkg::mpmc_state_t st_ff;
   logic [4:0] scan_ff;

   wire acc = psel & penable;
   wire fire = acc & pready_ff;
   wire [4:0] region = paddr[11:7];
   wire [4:0] idx = paddr[6:2];
   wire aligned = (paddr[1:0] == 2'h0);
   wire idx_ok = (idx < 5'(NP));
   wire hit_cfg = aligned & idx_ok & (region == mpmc_pkg::REGION_CFG);
   wire hit_dac = aligned & idx_ok & (region == mpmc_pkg::REGION_DAC);
   wire hit_res = aligned & idx_ok & (region == mpmc_pkg::REGION_RES);
   wire misc = aligned & (region == mpmc_pkg::REGION_MISC);
   wire hit_out = misc & (idx == mpmc_pkg::IDX_OUT);
   wire hit_in = misc & (idx == mpmc_pkg::IDX_IN);
   wire hit_stat = misc & (idx == mpmc_pkg::IDX_STAT);
   wire mapped = hit_cfg | hit_dac | hit_res | hit_out | hit_in | hit_stat;
   wire read_only = hit_res | hit_in | hit_stat;
   wire bad = !mapped | (pwrite & read_only);
   wire wr_ok = fire & pwrite & !bad;
   wire wr_cfg = wr_ok & hit_cfg;
   wire wr_dac = wr_ok & hit_dac;
   wire wr_out = wr_ok & hit_out;
   wire settling = (settle_ff != 16'h0000);
   wire [31:0] stat_word = {25'h0000000, scan_ff, (st_ff == mpmc_pkg::ST_WAIT), settling};
   wire [31:0] rd_word = hit_cfg ? 32'(cfg_ff[idx]) :
                         hit_dac ? 32'(dac_ff[idx]) :
                         hit_res ? 32'(mem_rdata) :
                         hit_out ? 32'(out_bits_ff) :
                         hit_in ? 32'(port_in) :
                         hit_stat ? stat_word : 32'h00000000;

   // one wait state: the result memory needs the setup cycle to present its word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= acc & !pready_ff;
         if (acc && !pready_ff) begin
            pslverr_ff <= bad;
            prdata_ff <= pwrite ? 32'h00000000 : rd_word;
         end
      end
   end

   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;

   // ==========================================================
   // per-port registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NP; i++) begin
            cfg_ff[i] <= mpmc_pkg::CFG_RST;
            dac_ff[i] <= mpmc_pkg::DAC_RST;
         end
         out_bits_ff <= '0;
      end else begin
         for (int i = 0; i < NP; i++) begin
            if (wr_cfg && (idx == 5'(i))) begin
               cfg_ff[i] <= pwdata[15:0];
            end
            if (wr_dac && (idx == 5'(i))) begin
               dac_ff[i] <= pwdata[11:0];
            end
         end
         if (wr_out) begin
            out_bits_ff <= pwdata[NP-1:0];
         end
      end
   end

   // settle window after a converter write, shown in status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_ff <= 16'h0000;
      end else if (wr_dac) begin
         settle_ff <= 16'(SETTLE_CYC);
      end else if (settling) begin
         settle_ff <= settle_ff - 16'h0001;
      end
   end

   // ==========================================================
   // port function selection
   wire [NP-1:0] nxt_out;
   wire [NP-1:0] nxt_oe;
   wire [NP-1:0] nxt_en;
   wire [NP*12-1:0] nxt_level;
   logic [NP-1:0] pin_out_ff;
   logic [NP-1:0] pin_oe_ff;
   logic [NP-1:0] dac_en_ff;
   logic [NP*12-1:0] dac_level_ff;

   for (genvar g = 0; g < NP; g++) begin : g_port
      // mode code from bits 15:12 of this port's word
      wire [3:0] mode = cfg_ff[g][mpmc_pkg::MODE_POS +: mpmc_pkg::MODE_W];
      wire [2:0] rng = cfg_ff[g][mpmc_pkg::RANGE_POS +: mpmc_pkg::RANGE_W];
      wire [4:0] assoc = cfg_ff[g][mpmc_pkg::ASSOC_POS +: mpmc_pkg::ASSOC_W];
      wire copy_invert = cfg_ff[g][mpmc_pkg::FLAG_POS];
      wire is_gpo = (mode == mpmc_pkg::MODE_GPO);
      wire is_copy = (mode == mpmc_pkg::MODE_COPY);
      wire is_mon = (mode == mpmc_pkg::MODE_DACMON);
      // plain converter output accepts three range codes only
      wire rng_ok = (rng == mpmc_pkg::RANGE_OUT_A) | (rng == mpmc_pkg::RANGE_OUT_B) |
                    (rng == mpmc_pkg::RANGE_OUT_C);
      wire is_dac = (mode == mpmc_pkg::MODE_DAC) & rng_ok;
      wire low_rng = (rng == mpmc_pkg::RANGE_LOW_A) | (rng == mpmc_pkg::RANGE_LOW_B);
      // any number of ports may read the same source pin
      wire src = (assoc < 5'(NP)) ? port_in[assoc] : 1'b0;
      wire [11:0] raw = dac_ff[g];
      // clip keeps the pin inside the 0V..5V window on the low range
      wire [11:0] clipped = (raw > CLIP_HI) ? CLIP_HI : ((raw < CLIP_LO) ? CLIP_LO : raw);
      // output follows its level bit; high level set by converter code
      // optional inversion of the copied value
      assign nxt_out[g] = is_gpo ? out_bits_ff[g] : (is_copy ? (src ^ copy_invert) : 1'b0);
      assign nxt_oe[g] = is_gpo | is_copy;
      // analog drive in the output modes
      assign nxt_en[g] = is_gpo | is_copy | is_dac | is_mon;
      assign nxt_level[g*12 +: 12] = (is_mon && low_rng) ? clipped : raw;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_ff <= '0;
         pin_oe_ff <= '0;
         dac_en_ff <= '0;
         dac_level_ff <= '0;
      end else begin
         pin_out_ff <= nxt_out;
         pin_oe_ff <= nxt_oe;
         dac_en_ff <= nxt_en;
         dac_level_ff <= nxt_level;
      end
   end

   assign pin_out = pin_out_ff;
   assign pin_oe = pin_oe_ff;
   assign dac_en = dac_en_ff;
   assign dac_level = dac_level_ff;

   // ==========================================================
   // sampling scheduler: round robin over ports in modes 6, 7, 8
   logic adc_start_ff;
   logic [4:0] adc_pos_ff;
   logic [4:0] adc_neg_ff;
   logic adc_diff_ff;
   logic [2:0] adc_range_ff;
   logic adc_ref_ff;
   logic [2:0] adc_avg_ff;

   wire [15:0] scan_cfg = cfg_ff[scan_ff];
   wire [3:0] scan_mode = scan_cfg[mpmc_pkg::MODE_POS +: mpmc_pkg::MODE_W];
   wire scan_diff = (scan_mode == mpmc_pkg::MODE_DIFF);
   // monitored outputs, single-ended inputs and differential inputs are sampled
   wire scan_adc = (scan_mode == mpmc_pkg::MODE_DACMON) | (scan_mode == mpmc_pkg::MODE_SE) | scan_diff;
   wire [4:0] scan_nxt = (scan_ff == 5'(NP - 1)) ? 5'h00 : scan_ff + 5'h01;
   wire res_wr = (st_ff == mpmc_pkg::ST_WAIT) & adc_done;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= mpmc_pkg::ST_SCAN;
         scan_ff <= 5'h00;
         adc_start_ff <= 1'b0;
      end else begin
         adc_start_ff <= 1'b0;
         unique case (st_ff)
            mpmc_pkg::ST_SCAN: begin
               if (scan_adc) begin
                  adc_start_ff <= 1'b1;
                  st_ff <= mpmc_pkg::ST_WAIT;
               end else begin
                  scan_ff <= scan_nxt;
               end
            end
            mpmc_pkg::ST_WAIT: begin
               if (adc_done) begin
                  scan_ff <= scan_nxt;
                  st_ff <= mpmc_pkg::ST_SCAN;
               end
            end
         endcase
      end
   end

   // conversion settings are latched with the start pulse and held for the conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_pos_ff <= 5'h00;
         adc_neg_ff <= 5'h00;
         adc_diff_ff <= 1'b0;
         adc_range_ff <= 3'h0;
         adc_ref_ff <= 1'b0;
         adc_avg_ff <= 3'h0;
      end else if ((st_ff == mpmc_pkg::ST_SCAN) && scan_adc) begin
         adc_pos_ff <= scan_ff;
         // negative input from the associated port
         adc_neg_ff <= scan_diff ? scan_cfg[mpmc_pkg::ASSOC_POS +: mpmc_pkg::ASSOC_W] : 5'h00;
         adc_diff_ff <= scan_diff;
         adc_range_ff <= scan_cfg[mpmc_pkg::RANGE_POS +: mpmc_pkg::RANGE_W];
         adc_ref_ff <= scan_cfg[mpmc_pkg::FLAG_POS];
         adc_avg_ff <= scan_cfg[mpmc_pkg::AVG_POS +: mpmc_pkg::AVG_W];
      end
   end

   assign adc_start = adc_start_ff;
   assign adc_pos = adc_pos_ff;
   assign adc_neg = adc_neg_ff;
   assign adc_diff = adc_diff_ff;
   assign adc_range = adc_range_ff;
   assign adc_ref = adc_ref_ff;
   assign adc_avg = adc_avg_ff;

   // conversion result kept per port for host reads
   mpmc_result_mem #(
      .DEPTH(NP),
      .WIDTH(12),
      .AW(5)
   ) u_res (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(res_wr),
      .wr_addr(scan_ff),
      .wr_data(adc_result),
      .rd_addr(idx),
      .rd_data_ff(mem_rdata)
   );

   // ==========================================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_mode_field: assert property (wr_cfg && idx == 5'h00 |=> cfg_ff[0][15:12] == $past(pwdata[15:12]))
      else $error("mode field not stored");
   a_port_indep: assert property (wr_cfg && idx == 5'h00 |=> $stable(cfg_ff[1]) && $stable(dac_ff[1]))
      else $error("write disturbed another port");
   a_gpo_level: assert property (g_port[0].is_gpo |=> pin_oe_ff[0] && pin_out_ff[0] == $past(out_bits_ff[0]))
      else $error("output does not follow level bit");
   a_copy_plain: assert property (g_port[1].is_copy && !g_port[1].copy_invert && g_port[1].assoc < 5'(NP)
      |=> pin_oe_ff[1] && pin_out_ff[1] == $past(port_in[g_port[1].assoc]))
      else $error("copy path wrong");
   a_copy_invert: assert property (g_port[2].is_copy && g_port[2].copy_invert && g_port[2].assoc < 5'(NP)
      |=> pin_out_ff[2] == !$past(port_in[g_port[2].assoc]))
      else $error("copy not inverted");
   a_shared_src: assert property (g_port[1].is_copy && g_port[2].is_copy && g_port[1].assoc == g_port[2].assoc
      |=> (pin_out_ff[1] ^ pin_out_ff[2]) == $past(g_port[1].copy_invert ^ g_port[2].copy_invert))
      else $error("shared source ports differ");
   a_dac_level: assert property (g_port[4].is_dac
      |=> dac_en_ff[4] && dac_level_ff[4*12 +: 12] == $past(dac_ff[4]))
      else $error("converter level not driven");
   a_mode5_range: assert property (g_port[4].mode == mpmc_pkg::MODE_DAC && !g_port[4].rng_ok
      |=> !dac_en_ff[4])
      else $error("invalid range accepted");
   a_clip_bound: assert property (g_port[6].is_mon && g_port[6].low_rng
      |=> dac_level_ff[6*12 +: 12] <= CLIP_HI && dac_level_ff[6*12 +: 12] >= CLIP_LO)
      else $error("monitor level not clipped");
   a_result_store: assert property (res_wr |=> u_res.mem_ff[$past(scan_ff)] == $past(adc_result))
      else $error("result not stored");
   a_start_pulse: assert property (adc_start_ff |=> !adc_start_ff && st_ff == mpmc_pkg::ST_WAIT)
      else $error("start pulse malformed");
   a_single_end: assert property (adc_start_ff && !adc_diff_ff
      |-> $past(scan_mode) == mpmc_pkg::MODE_SE || $past(scan_mode) == mpmc_pkg::MODE_DACMON)
      else $error("single-ended start from wrong mode");
   a_diff_neg: assert property (adc_start_ff && adc_diff_ff
      |-> adc_neg_ff == $past(scan_cfg[4:0]) && $past(scan_mode) == mpmc_pkg::MODE_DIFF)
      else $error("negative input not associated port");

   c_gpo_on: cover property (g_port[0].is_gpo ##1 pin_out_ff[0]);
   c_copy_on: cover property (g_port[1].is_copy ##1 pin_oe_ff[1]);
   c_sample_done: cover property (adc_start_ff ##[1:20] res_wr);
   c_bus_error: cover property (fire && pslverr_ff);
endmodule : mpmc_top

/* File: sim/mpmc_top_tb.sv */
module mpmc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // signals
   localparam int NP = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [NP-1:0] port_in = '0;
   logic adc_done = 1'b0;
   logic [11:0] adc_result = 12'h000;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, adc_start, adc_diff, adc_ref;
   wire logic [NP-1:0] pin_out, pin_oe, dac_en;
   wire logic [NP*12-1:0] dac_level;
   wire logic [4:0] adc_pos, adc_neg;
   wire logic [2:0] adc_range, adc_avg;
   logic [1:0] resp_cnt = 2'd0;
   logic [31:0] rd;
   logic er;
   int miscompares = 0;
   int cmp_count = 0;

   always #50 pclk = ~pclk;

   // short settle count keeps the status poll brief
   mpmc_top #(.NP(NP), .SETTLE_CYC(16)) i_mpmc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_in(port_in), .pin_out(pin_out), .pin_oe(pin_oe), .dac_en(dac_en),
      .dac_level(dac_level), .adc_start(adc_start), .adc_pos(adc_pos), .adc_neg(adc_neg), .adc_diff(adc_diff),
      .adc_range(adc_range), .adc_ref(adc_ref), .adc_avg(adc_avg), .adc_done(adc_done),
      .adc_result(adc_result));

   // ==========================================
   // sampler stand-in: answers each start four cycles later, result tagged with the port
   always @(posedge pclk) begin
      adc_done <= (adc_start !== 1'b1 && resp_cnt == 2'd1);
      adc_result <= 12'h500 | 12'(adc_pos);
      resp_cnt <= (adc_start === 1'b1) ? 2'd3 : ((resp_cnt != 2'd0) ? resp_cnt - 2'd1 : 2'd0);
   end

   // ==========================================
   // tasks
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      chk("pready", 32'h1, 32'(pready));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [31:0] cw(input logic [3:0] m, input logic f, input logic [2:0] r,
                                      input logic [2:0] av, input logic [4:0] as);
      return (32'(m) << mpmc_pkg::MODE_POS) | (32'(f) << mpmc_pkg::FLAG_POS) | (32'(r) << mpmc_pkg::RANGE_POS)
         | (32'(av) << mpmc_pkg::AVG_POS) | 32'(as);
   endfunction : cw

   task automatic wait_start(input logic [4:0] p);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!(adc_start === 1'b1 && adc_pos === p) && n < 300);
      chk("adc_start", 32'h1, 32'(adc_start === 1'b1 && adc_pos === p));
   endtask : wait_start

   task automatic settle();
      int n;
      n = 0;
      do begin
         apb(1'b0, 12'h088, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 40);
      chk("settling", 32'h0, 32'(rd[0]));
   endtask : settle

   initial begin
      #(20000 * 100);
      miscompares++;
      $display("MISMATCH watchdog expected done seen hang");
      report_and_stop();
   end

   // ==========================================
   // tests
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk("cfg1 reset", 32'h0, rd);
      apb(1'b0, 12'h104, 32'h0);
      chk("dac1 reset", 32'h0, rd);
      $display("test reset done");
      // converter level first, then mode 3
      // level before mode
      apb(1'b1, 12'h100, 32'h123);
      settle();
      apb(1'b1, 12'h000, cw(4'h3, 1'b0, 3'h0, 3'h0, 5'h0));
      apb(1'b1, 12'h080, 32'h1);
      repeat (3) @(posedge pclk);
      chk("oe0", 32'h1, 32'(pin_oe[0]));
      chk("out0 high", 32'h1, 32'(pin_out[0]));
      chk("level0", 32'h123, 32'(dac_level[11:0]));
      chk("en0", 32'h1, 32'(dac_en[0]));
      apb(1'b1, 12'h080, 32'h0);
      repeat (3) @(posedge pclk);
      chk("out0 low", 32'h0, 32'(pin_out[0]));
      apb(1'b0, 12'h000, 32'h0);
      chk("cfg0", cw(4'h3, 1'b0, 3'h0, 3'h0, 5'h0), rd);
      chk("cfg0 err", 32'h0, 32'(er));
      $display("test register output done");
      apb(1'b1, 12'h014, cw(4'h1, 1'b0, 3'h0, 3'h0, 5'h0));
      apb(1'b1, 12'h004, cw(4'h4, 1'b0, 3'h0, 3'h0, 5'd5));
      apb(1'b1, 12'h008, cw(4'h4, 1'b1, 3'h0, 3'h0, 5'd5));
      port_in[5] <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("copy high", 32'h1, 32'(pin_out[2:1]));
      chk("oe copy", 32'h3, 32'(pin_oe[2:1]));
      apb(1'b0, 12'h084, 32'h0);
      chk("in pins", 32'h20, rd);
      port_in[5] <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("copy low", 32'h2, 32'(pin_out[2:1]));
      chk("out0 kept", 32'h0, 32'(pin_out[0]));
      chk("oe0 kept", 32'h1, 32'(pin_oe[0]));
      $display("test copy output done");
      apb(1'b1, 12'h110, 32'h456);
      for (int r = 0; r < 8; r++) begin
         apb(1'b1, 12'h010, cw(4'h5, 1'b0, 3'(r), 3'h0, 5'h0));
         repeat (3) @(posedge pclk);
         chk("dac_en4", 32'(r >= 1 && r <= 3), 32'(dac_en[4]));
      end
      apb(1'b1, 12'h010, cw(4'h5, 1'b0, 3'h2, 3'h0, 5'h0));
      repeat (3) @(posedge pclk);
      chk("level4", 32'h456, 32'(dac_level[4*12 +: 12]));
      $display("test converter output done");
      // host keeps the code inside the low-range window first, then overdrives it to show the clip
      apb(1'b1, 12'h118, 32'h3ff);
      apb(1'b1, 12'h018, cw(4'h6, 1'b0, 3'h4, 3'h0, 5'h0));
      repeat (3) @(posedge pclk);
      chk("level6 in window", 32'h3ff, 32'(dac_level[6*12 +: 12]));
      apb(1'b1, 12'h118, 32'hfff);
      repeat (3) @(posedge pclk);
      chk("level6 clipped", 32'(mpmc_pkg::CLIP_HI_DEF), 32'(dac_level[6*12 +: 12]));
      wait_start(5'd6);
      repeat (8) @(posedge pclk);
      apb(1'b0, 12'h218, 32'h0);
      chk("result6", 32'h506, rd);
      apb(1'b1, 12'h018, cw(4'h6, 1'b0, 3'h1, 3'h0, 5'h0));
      repeat (3) @(posedge pclk);
      chk("level6 full", 32'hfff, 32'(dac_level[6*12 +: 12]));
      apb(1'b1, 12'h018, 32'h0);
      $display("test monitored output done");
      apb(1'b1, 12'h024, cw(4'h7, 1'b1, 3'h2, 3'h5, 5'h0));
      wait_start(5'd9);
      chk("se diff", 32'h0, 32'(adc_diff));
      chk("se setup", 32'h15, {26'h0, adc_range, adc_ref, adc_avg[1:0]});
      chk("se avg", 32'h5, 32'(adc_avg));
      repeat (8) @(posedge pclk);
      apb(1'b0, 12'h224, 32'h0);
      chk("result9", 32'h509, rd);
      apb(1'b1, 12'h024, 32'h0);
      apb(1'b1, 12'h028, cw(4'h8, 1'b0, 3'h1, 3'h2, 5'd3));
      wait_start(5'd10);
      chk("diff", 32'h1, 32'(adc_diff));
      chk("neg", 32'h3, 32'(adc_neg));
      repeat (8) @(posedge pclk);
      apb(1'b0, 12'h228, 32'h0);
      chk("result10", 32'h50a, rd);
      $display("test sampled inputs done");
      // refused accesses leave no trace
      apb(1'b0, 12'hffc, 32'h0);
      chk("unmapped err", 32'h1, 32'(er));
      apb(1'b1, 12'h002, 32'hffff);
      chk("misaligned err", 32'h1, 32'(er));
      apb(1'b1, 12'h200, 32'h777);
      chk("ro err", 32'h1, 32'(er));
      apb(1'b0, 12'h200, 32'h0);
      chk("result0", 32'h0, rd);
      $display("test refused access done");
      report_and_stop();
   end
endmodule : mpmc_top_tb
